// >>> common/l2c_map.vh
`ifndef L2C_MAP_VH
`define L2C_MAP_VH
// ==========================================================
// register offsets
`define L2C_OFS_LSC       12'h008
`define L2C_OFS_RAMCFG    12'h240
// ==========================================================
// field positions
`define L2C_LSC_EN        0
`define L2C_LSC_BUSY      1
`define L2C_RC_DSLOW      0
`define L2C_RC_TSLOW      1
`define L2C_RC_WS_LO      2
`define L2C_RC_DONE       31
// ==========================================================
// reset values
`define L2C_LSC_EN_RST    1'h1
`define L2C_RC_CFG_RST    4'h0
// ==========================================================
// cacheability attributes
`define L2C_CCA_CWB       2'h0
`define L2C_CCA_UC        2'h2
`define L2C_CCA_UCA       2'h3
// ==========================================================
// geometry and bus
`define L2C_LINE_BYTES    64
`define L2C_ADDR_W        48
`define L2C_AXSIZE        3'h5
`define L2C_BURST_INCR    2'h1
`define L2C_PIPE_STAGES   5
// ==========================================================
// timing
`define L2C_CLK_NS        10
`define L2C_INIT_DLY_NS   640
`define L2C_INIT_DLY_CYC  ((`L2C_INIT_DLY_NS + `L2C_CLK_NS - 1) / `L2C_CLK_NS)
`endif

// >>> logic/l2c_cache.v
// The plain strobed port was chosen for this implementation.
`include "l2c_map.vh"

module l2c_cache #(
  parameter        CACHE_KB    = 512,
  parameter [5:0]  MAX_RD_MISS = 6'h0C,
  parameter        ID_W        = 4,
  parameter [15:0] INIT_DELAY  = `L2C_INIT_DLY_CYC
) (
  input  wire          clk_sys,
  input  wire          rst,
  input  wire          reqValid,
  output wire          reqReady,
  input  wire          reqWrite,
  input  wire [47:0]   reqAddr,
  input  wire [511:0]  reqWdata,
  input  wire [63:0]   reqByteEn,
  input  wire [1:0]    reqAttr,
  output reg           respValid_r,
  output reg  [511:0]  respData_r,
  output reg           respErr_r,
  output reg           ownReq_r,
  input  wire          sharerPresent,
  input  wire          bypassMode,
  input  wire          autoinitInhibit,
  input  wire          mbistBusy,
  output reg           eccCorr_r,
  output reg           eccUnc_r,
  input  wire [11:0]   regAddr,
  input  wire [63:0]   regWdata,
  input  wire          regWr,
  input  wire          regRd,
  output reg  [63:0]   regRdata_r,
  output wire          arvalid,
  input  wire          arready,
  output wire [47:0]   araddr,
  output wire [ID_W-1:0] arid,
  output wire [7:0]    arlen,
  output wire [2:0]    arsize,
  output wire [1:0]    arburst,
  input  wire          rvalid,
  output wire          rready,
  input  wire [255:0]  rdata,
  input  wire [ID_W-1:0] rid,
  input  wire [1:0]    rresp,
  input  wire          rlast,
  output wire          awvalid,
  input  wire          awready,
  output wire [47:0]   awaddr,
  output wire [ID_W-1:0] awid,
  output wire [7:0]    awlen,
  output wire [2:0]    awsize,
  output wire [1:0]    awburst,
  output wire          wvalid,
  input  wire          wready,
  output wire [255:0]  wdata,
  output wire [31:0]   wstrb,
  output wire          wlast,
  input  wire          bvalid,
  output wire          bready,
  input  wire [ID_W-1:0] bid,
  input  wire [1:0]    bresp
);

  // ==========================================================
  // geometry
  localparam WAYS = (CACHE_KB == 256) ? 8 : 16;
  localparam LG   = (WAYS == 8) ? 3 : 4;
  localparam SETS = CACHE_KB * 1024 / `L2C_LINE_BYTES / WAYS;
  localparam SW   = $clog2(SETS);
  localparam IW   = SW + LG;
  localparam TW   = `L2C_ADDR_W - 6 - SW;
  localparam ENT  = SETS * WAYS;
  // sets and ways are powers of two, so the last entry is all ones
  localparam [IW-1:0] IDX_LAST = {IW{1'b1}};

  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_INIT = 4'h1;
  localparam [3:0] S_LOOK = 4'h2;
  localparam [3:0] S_AW   = 4'h3;
  localparam [3:0] S_W    = 4'h4;
  localparam [3:0] S_B    = 4'h5;
  localparam [3:0] S_AR   = 4'h6;
  localparam [3:0] S_R    = 4'h7;
  localparam [3:0] S_FILL = 4'h8;

  // ==========================================================
  // check-bit functions
  function [6:0] hsyn;
    input [63:0] d;
    integer p, k;
    begin
      hsyn = 7'h00;
      k = 0;
      for (p = 3; p < 72; p = p + 1) begin
        if ((p & (p - 1)) != 0) begin
          if (d[k])
            hsyn = hsyn ^ p[6:0];
          k = k + 1;
        end
      end
    end
  endfunction

  function [7:0] eenc;
    input [63:0] d;
    reg [6:0] h;
    begin
      h = hsyn(d);
      eenc = {^d ^ ^h, h};
    end
  endfunction

  // {double, single, corrected data}
  function [65:0] edec;
    input [63:0] d;
    input [7:0]  c;
    reg [6:0] s;
    reg odd;
    integer p, k;
    begin
      s = hsyn(d) ^ c[6:0];
      odd = ^d ^ ^c;
      edec = {~odd & (s != 7'h00), odd, d};
      k = 0;
      for (p = 3; p < 72; p = p + 1) begin
        if ((p & (p - 1)) != 0) begin
          if (odd && (p[6:0] == s))
            edec[k] = ~d[k];
          k = k + 1;
        end
      end
    end
  endfunction

  function [575:0] lenc;
    input [511:0] d;
    integer i;
    begin
      lenc[511:0] = d;
      for (i = 0; i < 8; i = i + 1)
        lenc[512+8*i +: 8] = eenc(d[64*i +: 64]);
    end
  endfunction

  function [513:0] ldec;
    input [575:0] m;
    reg [65:0] r;
    integer i;
    begin
      ldec = {514{1'b0}};
      for (i = 0; i < 8; i = i + 1) begin
        r = edec(m[64*i +: 64], m[512+8*i +: 8]);
        ldec[64*i +: 64] = r[63:0];
        ldec[512] = ldec[512] | r[64];
        ldec[513] = ldec[513] | r[65];
      end
    end
  endfunction

  function [71:0] tenc;
    input [63:0] e;
    begin
      tenc = {eenc(e), e};
    end
  endfunction

  function [511:0] mrg;
    input [511:0] o;
    input [511:0] n;
    input [63:0]  be;
    integer i;
    begin
      for (i = 0; i < 64; i = i + 1)
        mrg[8*i +: 8] = be[i] ? n[8*i +: 8] : o[8*i +: 8];
    end
  endfunction

  // tree bits point toward the next victim
  function [LG-1:0] pvic;
    input [WAYS-2:0] t;
    integer l, n;
    begin
      n = 1;
      for (l = 0; l < LG; l = l + 1)
        n = 2 * n + t[n-1];
      pvic = n[LG-1:0];
    end
  endfunction

  function [WAYS-2:0] pupd;
    input [WAYS-2:0] t;
    input [LG-1:0]   w;
    integer l, n;
    begin
      pupd = t;
      n = 1;
      for (l = 0; l < LG; l = l + 1) begin
        pupd[n-1] = ~w[LG-1-l];
        n = 2 * n + w[LG-1-l];
      end
    end
  endfunction

  // ==========================================================
  // state
  reg [71:0]     tagMem  [0:ENT-1];
  reg [575:0]    dataMem [0:ENT-1];
  reg [WAYS-2:0] plruMem [0:SETS-1];

  reg [3:0]      state_r;
  reg            qW_r;
  reg            qUc_r;
  reg [47:0]     qAddr_r;
  reg [511:0]    qData_r;
  reg [63:0]     qBe_r;
  reg [47:0]     mAddr_r;
  reg [511:0]    mData_r;
  reg [63:0]     mStrb_r;
  reg            mTwo_r;
  reg            mBeat_r;
  reg            mCache_r;
  reg [1:0]      mode_r;
  reg            rErr_r;
  reg [IW-1:0]   vicIdx_r;
  reg [3:0]      lookCnt_r;
  reg [ID_W-2:0] idCnt_r;
  reg [5:0]      rdOut_r;
  reg [41:0]     gthLine_r;
  reg [511:0]    gthData_r;
  reg [63:0]     gthStrb_r;
  reg [IW-1:0]   initIdx_r;
  reg            initDone_r;
  reg [15:0]     dlyCnt_r;
  reg            lscEn_r;
  reg            dSlow_r;
  reg            tSlow_r;
  reg [1:0]      wsStall_r;

  // ==========================================================
  // lookup
  wire [SW-1:0] qSet = qAddr_r[6+SW-1:6];
  wire [TW-1:0] qTag = qAddr_r[47:6+SW];
  wire [WAYS-2:0] plruCur = plruMem[qSet];

  reg [WAYS-1:0] hitV;
  reg [LG-1:0]   hitW;
  reg [LG-1:0]   vicW;
  reg            hitExcl;
  reg            tSgl;
  reg            tDbl;
  reg [65:0]     td;
  integer        w;

  always @* begin
    hitV = {WAYS{1'b0}};
    hitW = {LG{1'b0}};
    hitExcl = 1'b0;
    tSgl = 1'b0;
    tDbl = 1'b0;
    td = 66'h0;
    vicW = pvic(plruCur);
    for (w = WAYS - 1; w >= 0; w = w - 1) begin
      td = edec(tagMem[{qSet, w[LG-1:0]}][63:0], tagMem[{qSet, w[LG-1:0]}][71:64]);
      tSgl = tSgl | td[64];
      tDbl = tDbl | td[65];
      hitV[w] = td[63] & (td[TW-1:0] == qTag);
      if (hitV[w]) begin
        hitW = w[LG-1:0];
        hitExcl = td[61];
      end
      // an empty way beats the tree choice
      if (!td[63])
        vicW = w[LG-1:0];
    end
  end

  wire          hit     = |hitV;
  wire [IW-1:0] vIdx    = {qSet, vicW};
  wire [65:0]   vEnt    = edec(tagMem[vIdx][63:0], tagMem[vIdx][71:64]);
  wire [513:0]  lineRd  = ldec(dataMem[{qSet, hit ? hitW : vicW}]);
  wire [511:0]  newLine = mrg(hit ? lineRd[511:0] : mData_r, qData_r, qBe_r);
  // tag, way-select and data latencies add up behind the accept stage
  wire [3:0]    lookLat = (tSlow_r ? 4'h2 : 4'h1) + {2'h0, wsStall_r} + 4'h1
                          + (dSlow_r ? 4'h4 : 4'h2);

  // ==========================================================
  // request admission
  wire dlyDone = (dlyCnt_r == INIT_DELAY);
  wire initGo  = ~initDone_r & ~autoinitInhibit & lscEn_r & dlyDone & ~mbistBusy;
  wire caReq   = (reqAttr == `L2C_CCA_CWB) & ~bypassMode;
  wire ucaReq  = (reqAttr == `L2C_CCA_UCA) & ~bypassMode;
  wire gHas0   = |gthStrb_r[31:0];
  wire gHas1   = |gthStrb_r[63:32];
  wire gSame   = reqWrite & ucaReq & (reqAddr[47:6] == gthLine_r);
  wire flushNeed = (gHas0 | gHas1) & ((&gthStrb_r) | (reqValid & ~gSame));
  wire hf      = mAddr_r[5] | mBeat_r;

  // nothing is taken while a memory transaction is open
  assign reqReady = (state_r == S_IDLE) & ~initGo & ~flushNeed;

  // ==========================================================
  // memory port
  wire [ID_W-1:0] axId = mCache_r ? {1'b1, idCnt_r} : {ID_W{1'b0}};
  assign arvalid = (state_r == S_AR) & (rdOut_r < MAX_RD_MISS);
  assign araddr  = mAddr_r;
  assign arid    = axId;
  assign arlen   = 8'h01;
  assign arsize  = `L2C_AXSIZE;
  assign arburst = `L2C_BURST_INCR;
  assign rready  = (state_r == S_R);
  assign awvalid = (state_r == S_AW);
  assign awaddr  = mAddr_r;
  assign awid    = axId;
  assign awlen   = mTwo_r ? 8'h01 : 8'h00;
  assign awsize  = `L2C_AXSIZE;
  assign awburst = `L2C_BURST_INCR;
  assign wvalid  = (state_r == S_W);
  assign wdata   = hf ? mData_r[511:256] : mData_r[255:0];
  assign wstrb   = hf ? mStrb_r[63:32] : mStrb_r[31:0];
  assign wlast   = mBeat_r | ~mTwo_r;
  assign bready  = (state_r == S_B);

  // ==========================================================
  // array writes
  reg            tWe;
  reg            dWe;
  reg            pWe;
  reg [IW-1:0]   tIdx;
  reg [IW-1:0]   dIdx;
  reg [SW-1:0]   pSet;
  reg [71:0]     tVal;
  reg [575:0]    dVal;
  reg [WAYS-2:0] pVal;

  always @* begin
    tWe = 1'b0;
    dWe = 1'b0;
    pWe = 1'b0;
    tIdx = vicIdx_r;
    dIdx = vicIdx_r;
    pSet = qSet;
    tVal = tenc({1'b1, qW_r, qW_r | ~sharerPresent, {(61-TW){1'b0}}, qTag});
    dVal = lenc(newLine);
    pVal = pupd(plruCur, vicIdx_r[LG-1:0]);
    case (state_r)
      S_INIT: begin
        // tags and tree bits only; data words stay as they are
        tWe = 1'b1;
        tIdx = initIdx_r;
        tVal = 72'h0;
        pWe = 1'b1;
        pSet = initIdx_r[IW-1:LG];
        pVal = {(WAYS-1){1'b0}};
      end
      S_LOOK: begin
        if (lookCnt_r == 4'h0 && hit && !tDbl) begin
          pWe = 1'b1;
          pVal = pupd(plruCur, hitW);
          if (qW_r) begin
            tWe = 1'b1;
            dWe = 1'b1;
            tIdx = {qSet, hitW};
            dIdx = {qSet, hitW};
            tVal = tenc({3'h7, {(61-TW){1'b0}}, qTag});
          end
        end
      end
      S_FILL: begin
        tWe = 1'b1;
        dWe = 1'b1;
        pWe = 1'b1;
      end
      default: begin
        tWe = 1'b0;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (tWe)
      tagMem[tIdx] <= tVal;
    if (dWe)
      dataMem[dIdx] <= dVal;
    if (pWe)
      plruMem[pSet] <= pVal;
  end

  // ==========================================================
  // register read mux
  reg [63:0] rdVal;

  always @* begin
    rdVal = 64'h0;
    if (regAddr == `L2C_OFS_LSC) begin
      rdVal[`L2C_LSC_EN] = lscEn_r;
      rdVal[`L2C_LSC_BUSY] = (state_r == S_INIT);
    end else if (regAddr == `L2C_OFS_RAMCFG) begin
      rdVal[`L2C_RC_DSLOW] = dSlow_r;
      rdVal[`L2C_RC_TSLOW] = tSlow_r;
      rdVal[`L2C_RC_WS_LO +: 2] = wsStall_r;
      rdVal[`L2C_RC_DONE] = initDone_r;
    end
  end

  // ==========================================================
  // control
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= S_IDLE;
      qW_r <= 1'b0;
      qUc_r <= 1'b0;
      qAddr_r <= 48'h0;
      qData_r <= {512{1'b0}};
      qBe_r <= 64'h0;
      mAddr_r <= 48'h0;
      mData_r <= {512{1'b0}};
      mStrb_r <= 64'h0;
      mTwo_r <= 1'b0;
      mBeat_r <= 1'b0;
      mCache_r <= 1'b0;
      mode_r <= 2'h0;
      rErr_r <= 1'b0;
      vicIdx_r <= {IW{1'b0}};
      lookCnt_r <= 4'h0;
      idCnt_r <= {(ID_W-1){1'b0}};
      rdOut_r <= 6'h00;
      gthLine_r <= 42'h0;
      gthData_r <= {512{1'b0}};
      gthStrb_r <= 64'h0;
      initIdx_r <= {IW{1'b0}};
      initDone_r <= 1'b0;
      dlyCnt_r <= 16'h0000;
      lscEn_r <= `L2C_LSC_EN_RST;
      {wsStall_r, tSlow_r, dSlow_r} <= `L2C_RC_CFG_RST;
      regRdata_r <= 64'h0;
      respValid_r <= 1'b0;
      respData_r <= {512{1'b0}};
      respErr_r <= 1'b0;
      ownReq_r <= 1'b0;
      eccCorr_r <= 1'b0;
      eccUnc_r <= 1'b0;
    end else begin
      respValid_r <= 1'b0;
      ownReq_r <= 1'b0;
      eccCorr_r <= 1'b0;
      eccUnc_r <= 1'b0;
      if (!dlyDone)
        dlyCnt_r <= dlyCnt_r + 16'h0001;
      regRdata_r <= regRd ? rdVal : 64'h0;
      if (regWr && regAddr == `L2C_OFS_LSC)
        lscEn_r <= regWdata[`L2C_LSC_EN];
      else if (regWr && regAddr == `L2C_OFS_RAMCFG)
        {wsStall_r, tSlow_r, dSlow_r} <= regWdata[3:0];
      if (mCache_r && ((arvalid && arready) || (awvalid && awready)))
        idCnt_r <= idCnt_r + 1'b1;
      if (arvalid && arready)
        rdOut_r <= rdOut_r + 6'h01;
      else if (rvalid && rready && rlast)
        rdOut_r <= rdOut_r - 6'h01;
      case (state_r)
        S_IDLE: begin
          if (initGo) begin
            initIdx_r <= {IW{1'b0}};
            state_r <= S_INIT;
          end else if (flushNeed) begin
            // one beat when only one half was gathered
            mAddr_r <= {gthLine_r, ~gHas0, 5'h00};
            mTwo_r <= gHas0 & gHas1;
            mData_r <= gthData_r;
            mStrb_r <= gthStrb_r;
            gthStrb_r <= 64'h0;
            mode_r <= 2'h2;
            mCache_r <= 1'b0;
            mBeat_r <= 1'b0;
            state_r <= S_AW;
          end else if (reqValid) begin
            qW_r <= reqWrite;
            qUc_r <= ~caReq;
            qAddr_r <= reqAddr;
            qData_r <= reqWdata;
            qBe_r <= reqByteEn;
            mAddr_r <= {reqAddr[47:6], 6'h00};
            mData_r <= reqWdata;
            mStrb_r <= reqByteEn;
            mTwo_r <= 1'b1;
            mBeat_r <= 1'b0;
            mCache_r <= 1'b0;
            mode_r <= 2'h1;
            if (caReq) begin
              lookCnt_r <= lookLat - 4'h1;
              state_r <= S_LOOK;
            end else if (reqWrite && ucaReq) begin
              // store is posted into the gather line
              gthData_r <= mrg(gthData_r, reqWdata, reqByteEn);
              gthStrb_r <= gthStrb_r | reqByteEn;
              gthLine_r <= reqAddr[47:6];
              respValid_r <= 1'b1;
            end else if (reqWrite) begin
              state_r <= S_AW;
            end else begin
              rErr_r <= 1'b0;
              state_r <= S_AR;
            end
          end
        end
        S_INIT: begin
          initIdx_r <= initIdx_r + 1'b1;
          if (initIdx_r == IDX_LAST) begin
            initDone_r <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        S_LOOK: begin
          if (lookCnt_r != 4'h0) begin
            lookCnt_r <= lookCnt_r - 4'h1;
          end else begin
            // data of a missed way was never written and must not flag
            eccCorr_r <= tSgl | (hit & lineRd[512]);
            eccUnc_r <= tDbl | (hit & lineRd[513]);
            if (tDbl) begin
              respErr_r <= 1'b1;
              respValid_r <= 1'b1;
              state_r <= S_IDLE;
            end else if (hit) begin
              ownReq_r <= qW_r & ~hitExcl;
              respData_r <= lineRd[511:0];
              respErr_r <= ~qW_r & lineRd[513];
              respValid_r <= 1'b1;
              state_r <= S_IDLE;
            end else begin
              vicIdx_r <= vIdx;
              mCache_r <= 1'b1;
              rErr_r <= 1'b0;
              if (vEnt[63] && vEnt[62]) begin
                mAddr_r <= {vEnt[TW-1:0], qSet, 6'h00};
                mData_r <= lineRd[511:0];
                mStrb_r <= {64{1'b1}};
                mode_r <= 2'h0;
                state_r <= S_AW;
              end else begin
                state_r <= S_AR;
              end
            end
          end
        end
        S_AW: begin
          if (awready)
            state_r <= S_W;
        end
        S_W: begin
          if (wready) begin
            mBeat_r <= 1'b1;
            if (wlast)
              state_r <= S_B;
          end
        end
        S_B: begin
          // any returning ID is taken; only one write is ever open
          if (bvalid) begin
            mBeat_r <= 1'b0;
            if (mode_r == 2'h0) begin
              mAddr_r <= {qAddr_r[47:6], 6'h00};
              state_r <= S_AR;
            end else begin
              respValid_r <= (mode_r == 2'h1);
              respErr_r <= bresp[1];
              state_r <= S_IDLE;
            end
          end
        end
        S_AR: begin
          if (arvalid && arready) begin
            mBeat_r <= 1'b0;
            state_r <= S_R;
          end
        end
        S_R: begin
          if (rvalid) begin
            if (hf)
              mData_r[511:256] <= rdata;
            else
              mData_r[255:0] <= rdata;
            rErr_r <= rErr_r | rresp[1];
            mBeat_r <= 1'b1;
            if (rlast) begin
              if (qUc_r) begin
                respData_r <= {rdata, mData_r[255:0]};
                respErr_r <= rErr_r | rresp[1];
                respValid_r <= 1'b1;
                state_r <= S_IDLE;
              end else begin
                state_r <= S_FILL;
              end
            end
          end
        end
        S_FILL: begin
          ownReq_r <= qW_r;
          respData_r <= mData_r;
          respErr_r <= rErr_r;
          respValid_r <= 1'b1;
          state_r <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> dv/l2c_cache_sva.sv
module l2c_cache_sva (
  input wire        clk_sys,
  input wire        rst,
  input wire        arvalid,
  input wire        arready,
  input wire [7:0]  arlen,
  input wire [2:0]  arsize,
  input wire        awvalid,
  input wire        awready,
  input wire [7:0]  awlen,
  input wire        wvalid,
  input wire        wready,
  input wire        regRd,
  input wire [63:0] regRdata_r
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence arTaken; arvalid && arready; endsequence
  sequence awTaken; awvalid && awready; endsequence
  // ==========
  // memory port shape and ordering, register read data
  a_ar_shape:
    assert property (arvalid |-> arlen == 8'h01 && arsize == 3'h5) else $error("bad ar burst");
  a_aw_shape:
    assert property (awvalid |-> awlen <= 8'h01) else $error("bad aw burst");
  a_ar_hold:
    assert property (arvalid && !arready |=> arvalid) else $error("ar dropped");
  a_w_hold:
    assert property (wvalid && !wready |=> wvalid) else $error("w dropped");
  a_w_follows:
    assert property (awTaken |=> wvalid) else $error("w late");
  a_one_open:
    assert property (!(arvalid && awvalid)) else $error("ar and aw together");
  a_ar_spacing:
    assert property (arTaken |=> (!arvalid) [*2]) else $error("ar too soon");
  a_reg_stands:
    assert property (!regRd |=> regRdata_r == 64'h0) else $error("read data held");
endmodule

bind l2c_cache l2c_cache_sva u_l2c_cache_sva (.*);

// >>> dv/l2c_axi_mem.sv
module l2c_axi_mem (
  input  wire          clk_sys,
  input  wire          rst,
  input  wire          arvalid,
  output logic         arready,
  input  wire  [47:0]  araddr,
  input  wire  [3:0]   arid,
  output logic         rvalid,
  input  wire          rready,
  output logic [255:0] rdata,
  output logic [3:0]   rid,
  output logic [1:0]   rresp,
  output logic         rlast,
  input  wire          awvalid,
  output logic         awready,
  input  wire  [47:0]  awaddr,
  input  wire  [3:0]   awid,
  input  wire          wvalid,
  output logic         wready,
  input  wire  [255:0] wdata,
  input  wire  [31:0]  wstrb,
  input  wire          wlast,
  output logic         bvalid,
  input  wire          bready,
  output logic [3:0]   bid,
  output logic [1:0]   bresp
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [255:0] mem [logic [42:0]];
  logic [255:0] t;
  logic [47:0]  ra, wa;
  logic [1:0]   rn;
  logic         wo, st;
  function automatic logic [255:0] peek(input logic [42:0] k);
    return mem.exists(k) ? mem[k] : {8{k[31:0]}};
  endfunction
  // ==========
  // one burst each way; st halves the arready and wready rate
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {arready, rvalid, rlast, rid, rresp, rn, st, rdata} <= '0;
      {awready, wready, wo, bvalid, bid, bresp} <= '0;
    end else begin
      st <= ~st;
      arready <= arvalid & ~arready & ~rvalid & rn == 2'h0 & st;
      if (arvalid & arready) {ra, rid, rn} <= {araddr[47:5], 5'h00, arid, 2'h2};
      if (rvalid & rready) {rvalid, rn, ra} <= {1'h0, rn - 2'h1, ra + 48'h20};
      else if (!rvalid & rn != 2'h0) {rvalid, rdata, rlast} <= {1'h1, peek(ra[47:5]), rn == 2'h1};
      // idle rdata flips each cycle instead of holding the last beat
      else if (!rvalid) rdata <= ~rdata;
      awready <= awvalid & ~awready & ~wo & ~bvalid;
      if (awvalid & awready) {wa, bid, wo} <= {awaddr[47:5], 5'h00, awid, 1'h1};
      wready <= wvalid & ~wready & wo & st;
      if (wvalid & wready) begin
        t = peek(wa[47:5]);
        for (int i = 0; i < 32; i++) if (wstrb[i]) t[8*i +: 8] = wdata[8*i +: 8];
        mem[wa[47:5]] = t;
        wa <= wa + 48'h20;
        {wo, bvalid} <= {~wlast, wlast};
      end
      if (bvalid & bready) bvalid <= 1'h0;
    end
  end
endmodule

// >>> dv/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic         clk_sys, rst, reqValid, reqReady, reqWrite, respValid_r, respErr_r, own;
  logic         ownReq_r, sharerPresent, bypassMode, autoinitInhibit, mbistBusy, eccCorr_r;
  logic         eccUnc_r, regWr, regRd, arvalid, arready, rvalid, rready, rlast, awvalid;
  logic         awready, wvalid, wready, wlast, bvalid, bready;
  logic [1:0]   reqAttr, arburst, rresp, awburst, bresp;
  logic [2:0]   arsize, awsize;
  logic [3:0]   arid, rid, awid, bid;
  logic [7:0]   arlen, awlen;
  logic [11:0]  regAddr;
  logic [31:0]  wstrb;
  logic [47:0]  reqAddr, araddr, awaddr;
  logic [63:0]  reqByteEn, regWdata, regRdata_r, v;
  logic [255:0] rdata, wdata;
  logic [511:0] reqWdata, respData_r, e;
  int           fails, check_count, n;
  localparam logic [511:0] D = {16{32'hA5C30F1E}};
  // short init delay keeps the run brief
  l2c_cache #(.CACHE_KB(256), .INIT_DELAY(16'h0004)) u_l2c_cache (.*);
  l2c_axi_mem u_l2c_axi_mem (.*);
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  function automatic logic [511:0] line(input logic [47:0] a);
    return {{8{a[36:5] + 32'h1}}, {8{a[36:5]}}};
  endfunction
  // ==========
  // bus tasks and checking
  task summarize;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task quit;
    fails++;
    summarize();
  endtask
  task chk(input logic [511:0] g, x);
    check_count++;
    if (g !== x) begin
      fails++;
      $display("unexpected at %0t got %0h exp %0h", $time, g, x);
    end
  endtask
  task rw(input logic w, input logic [11:0] a, input logic [63:0] d);
    @(posedge clk_sys);
    {regWr, regRd, regAddr, regWdata} <= {w, ~w, a, d};
    @(posedge clk_sys);
    {regWr, regRd} <= 2'h0;
    #1 v = regRdata_r;
  endtask
  task rchk(input logic [11:0] a, input logic [63:0] x);
    rw(1'h0, a, 64'h0);
    chk(v, x);
  endtask
  task req(input logic w, input logic [1:0] t, input logic [47:0] a, input logic [63:0] b);
    @(posedge clk_sys);
    {reqValid, reqWrite, reqAttr, reqAddr, reqByteEn, own} <= {1'h1, w, t, a, b, 1'h0};
    #1;
    for (n = 0; reqReady !== 1'h1; n++) begin
      if (n > 99) quit();
      @(posedge clk_sys);
      #1;
    end
    @(posedge clk_sys);
    reqValid <= 1'h0;
    // posted answers pulse on the taking edge; look once it has settled
    #1;
    for (n = 0; respValid_r !== 1'h1; n++) begin
      if (n > 299) quit();
      own <= own | ownReq_r;
      @(posedge clk_sys);
      #1;
    end
  endtask
  task ld(input logic [1:0] t, input logic [47:0] a, input logic [511:0] x);
    req(1'h0, t, a, 64'h0);
    chk(respData_r, x);
    chk({respErr_r, eccCorr_r, eccUnc_r}, 3'h0);
  endtask
  // ==========
  // main sequence
  initial begin
    {reqValid, reqWrite, reqAttr, reqAddr, reqByteEn, regWr, regRd} = '0;
    {regAddr, regWdata, bypassMode, autoinitInhibit, own} = '0;
    {reqWdata, sharerPresent, mbistBusy, rst} = {D, 3'h7};
    fails = 0;
    check_count = 0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'h0;
    repeat (12) @(posedge clk_sys);
    rchk(12'h008, 64'h1);
    rchk(12'h240, 64'h0);
    mbistBusy <= 1'h0;
    repeat (20) @(posedge clk_sys);
    #1 chk(reqReady, 1'h0);
    rchk(12'h008, 64'h3);
    for (n = 0; v[31] !== 1'h1; n++) begin
      if (n > 2999) quit();
      rw(1'h0, 12'h240, 64'h0);
    end
    rchk(12'h240, 64'h80000000);
    rw(1'h1, 12'h240, 64'hF);
    rchk(12'h240, 64'h8000000F);
    rw(1'h1, 12'h100, 64'hF);
    rchk(12'h100, 64'h0);
    ld(2'h2, 48'h1000, line(48'h1000));
    req(1'h1, 2'h2, 48'h1000, '1);
    ld(2'h2, 48'h1000, D);
    ld(2'h0, 48'h2000, line(48'h2000));
    req(1'h1, 2'h0, 48'h2000, 64'hFF);
    chk(own | ownReq_r, 1'h1);
    e = line(48'h2000);
    e[63:0] = D[63:0];
    ld(2'h0, 48'h2000, e);
    ld(2'h2, 48'h2000, line(48'h2000));
    bypassMode <= 1'h1;
    ld(2'h0, 48'h2000, line(48'h2000));
    bypassMode <= 1'h0;
    req(1'h1, 2'h3, 48'h3000, 64'hFF00);
    e = line(48'h3000);
    e[127:64] = D[127:64];
    ld(2'h2, 48'h3000, e);
    req(1'h1, 2'h0, 48'h5000, 64'hFF);
    chk(own | ownReq_r, 1'h1);
    e = line(48'h5000);
    e[63:0] = D[63:0];
    ld(2'h0, 48'h5000, e);
    sharerPresent <= 1'h0;
    ld(2'h0, 48'h4000, line(48'h4000));
    req(1'h1, 2'h0, 48'h4000, 64'hFF);
    chk(own | ownReq_r, 1'h0);
    summarize();
  end
endmodule
